/* src/fan_monitor_config_status_regs.sv */
`timescale 1ns/100ps
// How it works
// [R1] pwm output driven only when enable set
// [R2] speed pulses passed only when tach enabled
// [R3] local interrupts gated by local enable bit
// [R4] remote interrupt enable cleared by power-up diode fault
// [R5] soft reset bit resets, self-clears, reads zero
// [R6] config two, status one, fraction reset values
// [R7] alarm speed flag does not reassert after read
// [R8] fan fault flag reasserts while failure remains
// [R9] remote high/low flags reassert while condition holds
// [R10] local high/low flags reassert while condition holds
// [R11] remote critical flag read-clears, no reassert
// [R12] diode error checked at power-up, read-proof
// [R13] local critical flag read-clears, no reassert
// [R14] therm pin low sets flag, forces full speed
// [R15] fraction bits: remote low three, local top two
// [R16] spin-up time decoded from bits two to zero
// [R17] pwm frequency decoded from bits five to three
// [R18] speed range divisor and failing speed
// [R19] fan characteristics and status two reset values
// [R20] slow fan when count exceeds high limit
// [R21] monitoring, except the therm pin, runs only while monitor enable set
// [R22] unused bits read zero, ignore writes
module fan_monitor_config_status_regs #(
	parameter int CLK_HZ = fan_mon_pkg::CLK_HZ_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst,
	input fan_mon_pkg::reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic monitor_enable,
	input wire logic mon_cycle,
	input fan_mon_pkg::mon_cond_t cond,
	input wire logic [7:0] tach_count,
	input wire logic [7:0] tach_high_limit,
	input wire logic diode_fault,
	input wire logic therm_in_n,
	input wire logic frac_valid,
	input wire logic [2:0] remote_frac,
	input wire logic [1:0] local_frac,
	input wire logic pwm_in,
	input wire logic tach_pulse_in,
	output logic pwm_out,
	output logic pwm_oe,
	output logic tach_pulse,
	output logic local_int_req,
	output logic remote_int_req,
	output logic soft_reset_out,
	output logic fan_full_speed,
	output fan_mon_pkg::fan_char_t fan_char
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] config_two_reg;
	logic [7:0] fan_char_reg;
	logic [7:0] ext_frac_reg;
	logic diode_err_reg;
	logic por_pending_reg;
	logic soft_reset_reg;
	logic [7:0] rdata_reg;
	logic rvalid_reg;
	logic pwm_out_reg;
	logic pwm_oe_reg;
	logic tach_pulse_reg;
	logic full_speed_reg;
	logic [fan_mon_pkg::NUM_FLAGS-1:0] flag_cond;
	logic [fan_mon_pkg::NUM_FLAGS-1:0] flag_sample;
	logic [fan_mon_pkg::NUM_FLAGS-1:0] flag_rd_clr;
	logic [fan_mon_pkg::NUM_FLAGS-1:0] flag_val;
	logic [7:0] status_one_val;
	logic [7:0] status_two_val;
	logic [7:0] rd_mux;
	logic wr_cfg;
	logic soft_req;
	logic rd_s1;
	logic rd_s2;
	logic sample;
	logic therm_low;

	// ----------------------------------------------------------------
	// decode of the register port
	// ----------------------------------------------------------------
	assign wr_cfg = reg_req.wr && (reg_req.addr == fan_mon_pkg::ADDR_CONFIG_TWO);
	assign soft_req = wr_cfg && reg_req.wdata[fan_mon_pkg::C2_SOFT_RESET]; // [R5]
	assign rd_s1 = reg_req.rd && (reg_req.addr == fan_mon_pkg::ADDR_STATUS_ONE);
	assign rd_s2 = reg_req.rd && (reg_req.addr == fan_mon_pkg::ADDR_STATUS_TWO);
	assign sample = mon_cycle && monitor_enable; // [R21]
	assign therm_low = !therm_in_n;

	// ----------------------------------------------------------------
	// power-up diode check, caught on the first edge after release
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			por_pending_reg <= 1'b1;
			diode_err_reg <= 1'b0;
		end else if (por_pending_reg) begin
			por_pending_reg <= 1'b0;
			diode_err_reg <= diode_fault; // [R12]
		end
	end

	// ----------------------------------------------------------------
	// config two: writes masked, soft reset restores defaults
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			config_two_reg <= fan_mon_pkg::CONFIG_TWO_RST; // [R6]
		end else if (por_pending_reg) begin
			// remote interrupts start disabled on a bad diode
			config_two_reg[fan_mon_pkg::C2_REM_INT_EN] <= !diode_fault; // [R4]
		end else if (soft_req) begin
			config_two_reg <= fan_mon_pkg::CONFIG_TWO_RST; // [R5]
			config_two_reg[fan_mon_pkg::C2_REM_INT_EN] <= !diode_err_reg; // [R4]
		end else if (wr_cfg) begin
			config_two_reg <= (reg_req.wdata & fan_mon_pkg::CONFIG_TWO_WR_MASK)
				| (config_two_reg & ~fan_mon_pkg::CONFIG_TWO_WR_MASK); // [R22]
		end
	end

	// soft reset pulse, one cycle; the stored bit never holds a 1
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			soft_reset_reg <= 1'b0;
		end else begin
			soft_reset_reg <= soft_req; // [R5]
		end
	end

	// ----------------------------------------------------------------
	// fan characteristics, plain read/write
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fan_char_reg <= fan_mon_pkg::FAN_CHAR_RST; // [R19]
		end else if (soft_req) begin
			fan_char_reg <= fan_mon_pkg::FAN_CHAR_RST;
		end else if (reg_req.wr && (reg_req.addr == fan_mon_pkg::ADDR_FAN_CHAR)) begin
			fan_char_reg <= reg_req.wdata;
		end
	end

	fan_char_decode #(
		.CLK_HZ(CLK_HZ)
	) u_char_decode (
		.core_clk(core_clk),
		.rst(rst),
		.char_byte(fan_char_reg), // [R16] [R17] [R18]
		.decoded(fan_char)
	);

	// ----------------------------------------------------------------
	// extended fraction, captured from the converter, reserved bits zero
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ext_frac_reg <= fan_mon_pkg::EXT_FRAC_RST; // [R6]
		end else if (soft_req) begin
			ext_frac_reg <= fan_mon_pkg::EXT_FRAC_RST;
		end else if (frac_valid && monitor_enable) begin
			ext_frac_reg <= 8'h00; // [R22]
			ext_frac_reg[fan_mon_pkg::EXT_REM_LSB +: 3] <= remote_frac; // [R15]
			ext_frac_reg[fan_mon_pkg::EXT_LOC_LSB +: 2] <= local_frac; // [R15]
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	// conditions and their sample strobes, slot order as in the package
	always_comb begin
		flag_cond[0] = cond.fan_alarm; // [R7]
		flag_cond[1] = tach_count > tach_high_limit; // [R8] [R20]
		flag_cond[2] = cond.remote_high; // [R9]
		flag_cond[3] = cond.remote_low; // [R9]
		flag_cond[4] = cond.remote_crit; // [R11]
		flag_cond[5] = cond.local_high; // [R10]
		flag_cond[6] = cond.local_low; // [R10]
		flag_cond[7] = cond.local_crit; // [R13]
		flag_cond[8] = therm_low; // [R14]
		flag_sample = {fan_mon_pkg::NUM_FLAGS{sample}};
		// fault needs the tach path enabled to mean anything
		flag_sample[1] = sample && config_two_reg[fan_mon_pkg::C2_TACH_EN];
		// the therm pin is watched every cycle, monitor or not
		flag_sample[8] = 1'b1;
		flag_rd_clr = {{2{rd_s2}}, {7{rd_s1}}};
	end

	for (genvar i = 0; i < fan_mon_pkg::NUM_FLAGS; i++) begin : g_flag
		status_flag #(
			.REARM(fan_mon_pkg::FLAG_REARM_MASK[i])
		) u_flag (
			.core_clk(core_clk),
			.rst(rst),
			.soft_clr(soft_req),
			.sample(flag_sample[i]),
			.cond(flag_cond[i]),
			.rd_clr(flag_rd_clr[i]),
			.flag(flag_val[i])
		);
	end

	// the diode bit sits outside the read-clear path
	assign status_one_val = {flag_val[6], flag_val[5], diode_err_reg, flag_val[4],
		flag_val[3], flag_val[2], flag_val[1], flag_val[0]}; // [R12]
	assign status_two_val = {flag_val[8], flag_val[7], 6'h00}; // [R22]

	// ----------------------------------------------------------------
	// read data, one cycle after the strobe; unmapped reads zero
	// ----------------------------------------------------------------
	always_comb begin
		case (reg_req.addr)
			fan_mon_pkg::ADDR_CONFIG_TWO: rd_mux = config_two_reg & 8'h7f; // [R5]
			fan_mon_pkg::ADDR_STATUS_ONE: rd_mux = status_one_val;
			fan_mon_pkg::ADDR_STATUS_TWO: rd_mux = status_two_val;
			fan_mon_pkg::ADDR_EXT_FRAC: rd_mux = ext_frac_reg;
			fan_mon_pkg::ADDR_FAN_CHAR: rd_mux = fan_char_reg;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_req.rd;
			if (reg_req.rd) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin gating and interrupt requests
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pwm_out_reg <= 1'b0;
			pwm_oe_reg <= 1'b0;
			tach_pulse_reg <= 1'b0;
			full_speed_reg <= 1'b0;
		end else begin
			pwm_oe_reg <= config_two_reg[fan_mon_pkg::C2_PWM_EN]; // [R1]
			pwm_out_reg <= config_two_reg[fan_mon_pkg::C2_PWM_EN] && pwm_in; // [R1]
			tach_pulse_reg <= tach_pulse_in && monitor_enable
				&& config_two_reg[fan_mon_pkg::C2_TACH_EN]; // [R2] [R21]
			full_speed_reg <= therm_low || flag_val[8]; // [R14]
		end
	end

	// level requests; the interrupt pin logic outside combines them
	assign local_int_req = config_two_reg[fan_mon_pkg::C2_LOC_INT_EN]
		&& (flag_val[5] || flag_val[6] || flag_val[7]); // [R3]
	assign remote_int_req = config_two_reg[fan_mon_pkg::C2_REM_INT_EN]
		&& (flag_val[2] || flag_val[3] || flag_val[4]); // [R4]

	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;
	assign pwm_out = pwm_out_reg;
	assign pwm_oe = pwm_oe_reg;
	assign tach_pulse = tach_pulse_reg;
	assign soft_reset_out = soft_reset_reg;
	assign fan_full_speed = full_speed_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence seq_soft_write;
		soft_req && !por_pending_reg;
	endsequence

	sequence seq_s1_read_idle;
		rd_s1 && !sample;
	endsequence

	a_pwm_gate: assert property (@(posedge core_clk) disable iff (rst) // [R1]
		!config_two_reg[fan_mon_pkg::C2_PWM_EN] |=> !pwm_oe && !pwm_out)
		else $error("pwm driven while disabled");

	a_tach_gate: assert property (@(posedge core_clk) disable iff (rst) // [R2]
		tach_pulse |-> $past(config_two_reg[fan_mon_pkg::C2_TACH_EN]) && $past(monitor_enable))
		else $error("speed pulse passed while disabled");

	a_local_int: assert property (@(posedge core_clk) disable iff (rst) // [R3]
		local_int_req |-> config_two_reg[fan_mon_pkg::C2_LOC_INT_EN])
		else $error("local interrupt while gated");

	a_soft_reset: assert property (@(posedge core_clk) disable iff (rst) // [R5]
		seq_soft_write |=> soft_reset_out && (fan_char_reg == fan_mon_pkg::FAN_CHAR_RST)
			##1 !soft_reset_out)
		else $error("soft reset pulse or defaults wrong");

	a_rearm_high: assert property (@(posedge core_clk) disable iff (rst) // [R9]
		rd_s1 && sample && cond.remote_high |=> status_one_val[2])
		else $error("remote high lost against read");

	a_read_clear: assert property (@(posedge core_clk) disable iff (rst) // [R10]
		seq_s1_read_idle |=> !status_one_val[6] && !status_one_val[7])
		else $error("local flags not cleared by read");

	a_diode_keep: assert property (@(posedge core_clk) disable iff (rst) // [R12]
		rd_s1 && diode_err_reg |=> $stable(status_one_val[fan_mon_pkg::S1_DIODE_ERR]))
		else $error("diode error cleared by read");

	a_therm_full: assert property (@(posedge core_clk) disable iff (rst) // [R14]
		therm_low && !soft_req |=> fan_full_speed)
		else $error("therm low did not force full speed");

	// only a fresh fall is sure to set: a read may clear the flag mid-episode
	a_therm_flag: assert property (@(posedge core_clk) disable iff (rst) // [R14]
		$fell(therm_in_n) && !soft_req |=> status_two_val[7])
		else $error("therm fall not flagged");

	a_slow_fan: assert property (@(posedge core_clk) disable iff (rst) // [R20]
		sample && config_two_reg[fan_mon_pkg::C2_TACH_EN] && (tach_count > tach_high_limit)
			&& !soft_req |=> status_one_val[1])
		else $error("slow fan not flagged");

	a_no_monitor: assert property (@(posedge core_clk) disable iff (rst) // [R21]
		!monitor_enable && !rd_s1 && !soft_req && !por_pending_reg
			|=> $stable(status_one_val))
		else $error("status moved while monitoring off");

	a_unused_zero: assert property (@(posedge core_clk) disable iff (rst) // [R22]
		reg_req.rd && (reg_req.addr == fan_mon_pkg::ADDR_STATUS_TWO)
			|=> reg_rvalid && (reg_rdata[5:0] == 6'h00))
		else $error("status two unused bits not zero");

	a_frac_hold: assert property (@(posedge core_clk) disable iff (rst) // [R15]
		!(frac_valid && monitor_enable) && !soft_req |=> $stable(ext_frac_reg))
		else $error("fraction bits moved without a capture");

	a_reset_bit_zero: assert property (@(posedge core_clk) disable iff (rst) // [R5]
		reg_req.rd && (reg_req.addr == fan_mon_pkg::ADDR_CONFIG_TWO)
			|=> !reg_rdata[fan_mon_pkg::C2_SOFT_RESET])
		else $error("soft reset bit read back as one");

	a_diode_mask: assert property (@(posedge core_clk) disable iff (rst) // [R4]
		$fell(por_pending_reg) && diode_err_reg
			|-> !config_two_reg[fan_mon_pkg::C2_REM_INT_EN])
		else $error("remote interrupts enabled despite diode fault");
endmodule

/* src/fan_mon_pkg.sv */
package fan_mon_pkg;
	// ----------------------------------------------------------------
	// register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONFIG_TWO = 8'h01;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h02;
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h03;
	localparam logic [7:0] ADDR_EXT_FRAC = 8'h06;
	localparam logic [7:0] ADDR_FAN_CHAR = 8'h20;
	localparam logic [7:0] CONFIG_TWO_RST = 8'h7f;
	localparam logic [7:0] STATUS_ONE_RST = 8'h00;
	localparam logic [7:0] STATUS_TWO_RST = 8'h00;
	localparam logic [7:0] EXT_FRAC_RST = 8'h00;
	localparam logic [7:0] FAN_CHAR_RST = 8'h5d;
	// bits 0,1,2,4,5,6 take writes; bit 3 holds its reset value, bit 7 reads 0
	localparam logic [7:0] CONFIG_TWO_WR_MASK = 8'h77;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int C2_PWM_EN = 0;
	localparam int C2_TACH_EN = 2;
	localparam int C2_LOC_INT_EN = 4;
	localparam int C2_REM_INT_EN = 5;
	localparam int C2_SOFT_RESET = 7;
	localparam int S1_DIODE_ERR = 5;
	localparam int EXT_REM_LSB = 0;
	localparam int EXT_LOC_LSB = 6;
	localparam int FC_SPIN_LSB = 0;
	localparam int FC_FREQ_LSB = 3;
	localparam int FC_RANGE_LSB = 6;
	// flag slots: 0 alarm, 1 fan fault, 2 rem high, 3 rem low, 4 rem crit,
	// 5 loc high, 6 loc low, 7 loc crit, 8 therm pin
	localparam int NUM_FLAGS = 9;
	localparam logic [8:0] FLAG_REARM_MASK = 9'h06e;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ_DEFAULT = 10000000;
	localparam int MS_PER_S = 1000;
	localparam int CENTI_PER_UNIT = 100;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic fan_alarm;
		logic remote_high;
		logic remote_low;
		logic remote_crit;
		logic local_high;
		logic local_low;
		logic local_crit;
	} mon_cond_t;

	typedef struct packed {
		logic [13:0] spin_up_ms;
		logic [26:0] spin_up_cycles;
		logic [19:0] pwm_period_cycles;
		logic [3:0] speed_divisor;
		logic [11:0] fail_rpm;
	} fan_char_t;

	// spin-up time in ms per code
	function automatic logic [13:0] spin_up_ms(input logic [2:0] code);
		case (code)
			3'h0: return 14'h00c8;
			3'h1: return 14'h0190;
			3'h2: return 14'h0258;
			3'h3: return 14'h0320;
			3'h4: return 14'h03e8;
			3'h5: return 14'h07d0;
			3'h6: return 14'h0fa0;
			default: return 14'h1f40;
		endcase
	endfunction

	// pwm frequency in hundredths of a hertz per code
	function automatic logic [13:0] pwm_centihz(input logic [2:0] code);
		case (code)
			3'h0: return 14'h0492;
			3'h1: return 14'h0618;
			3'h2: return 14'h0924;
			3'h3: return 14'h0c35;
			3'h4: return 14'h0ea6;
			3'h5: return 14'h1252;
			3'h6: return 14'h186a;
			default: return 14'h2486;
		endcase
	endfunction

	// failing speed in rpm per range code
	function automatic logic [11:0] fail_rpm(input logic [1:0] code);
		case (code)
			2'h0: return 12'ha57;
			2'h1: return 12'h52c;
			2'h2: return 12'h296;
			default: return 12'h14b;
		endcase
	endfunction
endpackage

/* src/status_flag.sv */
`timescale 1ns/100ps
// one sticky status bit; REARM picks per-cycle reassert or once-per-episode
module status_flag #(
	parameter bit REARM = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic soft_clr,
	input wire logic sample,
	input wire logic cond,
	input wire logic rd_clr,
	output logic flag
);
	logic flag_reg;
	logic armed_reg;
	logic set_now;

	// once-mode stays quiet until a sample shows the condition gone
	assign set_now = sample && cond && (REARM || armed_reg);
	assign flag = flag_reg;

	// ----------------------------------------------------------------
	// flag: set beats a read clear in the same cycle
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flag_reg <= 1'b0;
		end else if (soft_clr) begin
			flag_reg <= 1'b0;
		end else if (set_now) begin
			flag_reg <= 1'b1;
		end else if (rd_clr) begin
			flag_reg <= 1'b0;
		end
	end

	// arming for once-mode
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			armed_reg <= 1'b1;
		end else if (soft_clr) begin
			armed_reg <= 1'b1;
		end else if (set_now) begin
			armed_reg <= 1'b0;
		end else if (sample && !cond) begin
			armed_reg <= 1'b1;
		end
	end
endmodule

/* src/fan_char_decode.sv */
`timescale 1ns/100ps
// turns the fan characteristics byte into times, periods and ranges
module fan_char_decode #(
	parameter int CLK_HZ = fan_mon_pkg::CLK_HZ_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] char_byte,
	output fan_mon_pkg::fan_char_t decoded
);
	function automatic fan_mon_pkg::fan_char_t decode(input logic [7:0] b);
		fan_mon_pkg::fan_char_t d;
		logic [2:0] spin;
		logic [2:0] freq;
		logic [1:0] range;
		spin = b[fan_mon_pkg::FC_SPIN_LSB +: 3];
		freq = b[fan_mon_pkg::FC_FREQ_LSB +: 3];
		range = b[fan_mon_pkg::FC_RANGE_LSB +: 2];
		d.spin_up_ms = fan_mon_pkg::spin_up_ms(spin);
		// 64-bit math: clock rate times hundred overflows 32 bits at high rates
		d.spin_up_cycles = 27'(64'(d.spin_up_ms) * 64'(CLK_HZ / fan_mon_pkg::MS_PER_S));
		d.pwm_period_cycles = 20'(64'(CLK_HZ) * 64'(fan_mon_pkg::CENTI_PER_UNIT)
			/ 64'(fan_mon_pkg::pwm_centihz(freq)));
		d.speed_divisor = 4'h1 << range;
		d.fail_rpm = fan_mon_pkg::fail_rpm(range);
		return d;
	endfunction

	localparam fan_mon_pkg::fan_char_t DECODED_RST = decode(fan_mon_pkg::FAN_CHAR_RST);

	// registered so the divide never sits in a downstream path
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			decoded <= DECODED_RST;
		end else begin
			decoded <= decode(char_byte);
		end
	end
endmodule

/* dv/fan_host_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// management bus host, reduced to the block's strobe port
// ----------------------------------------------------------------
module fan_host_model (
	input wire logic core_clk,
	output fan_mon_pkg::reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial reg_req = '0;

	// one-cycle write strobe; idle fields scrambled so stale values never look valid
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge core_clk);
		reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
	endtask

	// answer is taken in the cycle after the taking edge
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge core_clk);
		reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge core_clk);
		reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'h5a};
		#1;
		v = reg_rvalid;
		d = reg_rdata;
	endtask
endmodule

/* dv/test_fan_monitor_config_status_regs.sv */
`timescale 1ns/100ps
module test_fan_monitor_config_status_regs;
	logic core_clk, rst, monitor_enable, mon_cycle, diode_fault, therm_in_n, frac_valid;
	logic pwm_in, tach_pulse_in, reg_rvalid, pwm_out, pwm_oe, tach_pulse, rd_ok;
	logic local_int_req, remote_int_req, soft_reset_out, fan_full_speed;
	logic [7:0] reg_rdata, tach_count, tach_high_limit, rd_val;
	logic [2:0] remote_frac;
	logic [1:0] local_frac;
	fan_mon_pkg::reg_req_t reg_req;
	fan_mon_pkg::mon_cond_t cond;
	fan_mon_pkg::fan_char_t fan_char;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;

	fan_monitor_config_status_regs dut_u (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .monitor_enable(monitor_enable),
		.mon_cycle(mon_cycle), .cond(cond), .tach_count(tach_count),
		.tach_high_limit(tach_high_limit), .diode_fault(diode_fault), .therm_in_n(therm_in_n),
		.frac_valid(frac_valid), .remote_frac(remote_frac), .local_frac(local_frac),
		.pwm_in(pwm_in), .tach_pulse_in(tach_pulse_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
		.tach_pulse(tach_pulse), .local_int_req(local_int_req),
		.remote_int_req(remote_int_req), .soft_reset_out(soft_reset_out),
		.fan_full_speed(fan_full_speed), .fan_char(fan_char));
	fan_host_model host_u (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	// 100 ns clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// read, then check both the valid strobe and the data
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host_u.read(a, rd_val, rd_ok);
		chk("reg_rvalid", 32'h1, 32'(rd_ok));
		chk($sformatf("reg %h", a), 32'(exp), 32'(rd_val));
	endtask

	task automatic sample(input logic [6:0] c);
		@(posedge core_clk);
		cond <= c;
		mon_cycle <= 1'b1;
		@(posedge core_clk);
		mon_cycle <= 1'b0;
	endtask

	// diode level held past release: it is sampled on the first edge after
	task automatic do_reset(input logic df);
		rst <= 1'b1;
		diode_fault <= df;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	task automatic stop_test;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// hang guard, well above the hundred or so cycles the sequence needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		monitor_enable = 1'b0;
		mon_cycle = 1'b0;
		cond = '0;
		diode_fault = 1'b0;
		therm_in_n = 1'b1;
		frac_valid = 1'b0;
		remote_frac = 3'h0;
		local_frac = 2'h0;
		pwm_in = 1'b1;
		tach_pulse_in = 1'b1;
		tach_count = 8'h11;
		tach_high_limit = 8'h10;
		do_reset(1'b0);
		rchk(8'h01, 8'h7f);
		rchk(8'h02, 8'h00);
		rchk(8'h03, 8'h00);
		rchk(8'h06, 8'h00);
		rchk(8'h20, 8'h5d);
		rchk(8'h07, 8'h00);
		chk("spin_up_ms", 32'h7d0, 32'(fan_char.spin_up_ms));
		chk("pwm_period", 32'h4e200, 32'(fan_char.pwm_period_cycles));
		chk("fail_rpm", 32'h52c, 32'(fan_char.fail_rpm));
		chk("pwm_out", 32'h1, 32'(pwm_out));
		chk("pwm_oe_on", 32'h1, 32'(pwm_oe));
		chk("tach_off", 32'h0, 32'(tach_pulse));
		@(posedge core_clk);
		monitor_enable <= 1'b1;
		settle();
		chk("tach_on", 32'h1, 32'(tach_pulse));
		// enabled outputs must follow their sources, not just the enables
		@(posedge core_clk);
		pwm_in <= 1'b0;
		tach_pulse_in <= 1'b0;
		settle();
		chk("pwm_follow", 32'h0, 32'(pwm_out));
		chk("tach_follow", 32'h0, 32'(tach_pulse));
		@(posedge core_clk);
		pwm_in <= 1'b1;
		tach_pulse_in <= 1'b1;
		// enables cleared: no pwm drive, no tach, bit3 fixed
		host_u.write(8'h01, 8'h00);
		settle();
		chk("pwm_oe", 32'h0, 32'(pwm_oe));
		chk("pwm_out", 32'h0, 32'(pwm_out));
		chk("tach_gated", 32'h0, 32'(tach_pulse));
		rchk(8'h01, 8'h08);
		// flags set with interrupts masked, then unmasked
		host_u.write(8'h01, 8'h05);
		sample(7'h7f);
		#1;
		chk("loc_int_masked", 32'h0, 32'(local_int_req));
		chk("rem_int_masked", 32'h0, 32'(remote_int_req));
		host_u.write(8'h01, 8'h35);
		settle();
		chk("loc_int", 32'h1, 32'(local_int_req));
		chk("rem_int", 32'h1, 32'(remote_int_req));
		rchk(8'h02, 8'hdf);
		rchk(8'h03, 8'h40);
		chk("loc_int_clr", 32'h0, 32'(local_int_req));
		// same conditions again: once-bits stay down
		sample(7'h7f);
		rchk(8'h02, 8'hce);
		rchk(8'h03, 8'h00);
		// count equal to limit is not a slow fan
		@(posedge core_clk);
		tach_count <= 8'h10;
		sample(7'h00);
		rchk(8'h02, 8'h00);
		@(posedge core_clk);
		monitor_enable <= 1'b0;
		sample(7'h7f);
		rchk(8'h02, 8'h00);
		@(posedge core_clk);
		monitor_enable <= 1'b1;
		cond <= '0;
		// remote high sampled on the edge that takes a status read: the set wins
		fork
			rchk(8'h02, 8'h00);
			sample(7'h20);
		join
		chk("rem_int_race", 32'h1, 32'(remote_int_req));
		rchk(8'h02, 8'h04);
		// overtemperature pin pulled low for one cycle
		@(posedge core_clk);
		therm_in_n <= 1'b0;
		@(posedge core_clk);
		therm_in_n <= 1'b1;
		#1;
		chk("full_speed", 32'h1, 32'(fan_full_speed));
		rchk(8'h03, 8'h80);
		settle();
		chk("full_speed_off", 32'h0, 32'(fan_full_speed));
		// fraction capture, then a write to the read-only copy
		@(posedge core_clk);
		frac_valid <= 1'b1;
		remote_frac <= 3'h5;
		local_frac <= 2'h2;
		@(posedge core_clk);
		frac_valid <= 1'b0;
		rchk(8'h06, 8'h85);
		host_u.write(8'h06, 8'hff);
		rchk(8'h06, 8'h85);
		// fan characteristic corner codes
		host_u.write(8'h20, 8'hc7);
		rchk(8'h20, 8'hc7);
		chk("spin_up_ms", 32'h1f40, 32'(fan_char.spin_up_ms));
		chk("spin_cycles", 32'h4c4b400, 32'(fan_char.spin_up_cycles));
		chk("divisor", 32'h8, 32'(fan_char.speed_divisor));
		chk("fail_rpm", 32'h14b, 32'(fan_char.fail_rpm));
		host_u.write(8'h20, 8'h38);
		settle();
		chk("pwm_period", 32'h1a1c7, 32'(fan_char.pwm_period_cycles));
		chk("spin_up_ms", 32'hc8, 32'(fan_char.spin_up_ms));
		chk("divisor", 32'h1, 32'(fan_char.speed_divisor));
		chk("fail_rpm", 32'ha57, 32'(fan_char.fail_rpm));
		// soft reset pulse and its self-clearing bit
		host_u.write(8'h01, 8'h80);
		#1;
		chk("soft_reset", 32'h1, 32'(soft_reset_out));
		@(posedge core_clk);
		#1;
		chk("soft_reset_end", 32'h0, 32'(soft_reset_out));
		rchk(8'h01, 8'h7f);
		rchk(8'h20, 8'h5d);
		rchk(8'h06, 8'h00);
		// second power-up with a faulty diode, reset raised on an edge
		@(posedge core_clk);
		do_reset(1'b1);
		rchk(8'h01, 8'h5f);
		rchk(8'h02, 8'h20);
		rchk(8'h02, 8'h20);
		stop_test();
	end
endmodule
